// File: bench/sadc_ctrl_tb.sv
// testbench: register-level tests of the converter control
`timescale 1ns/10ps
`default_nettype none
module sadc_ctrl_tb
   import sadc_pkg::*;
;
   //=============================================================
   // signals and design
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [ADDR_W-1:0] reg_addr = 3'h0;
   logic [DATA_W-1:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [DATA_W-1:0] reg_rdata;
   logic cmp_high = 1'b0;
   logic [APPROX_BITS-1:0] tap_code;
   logic sample_en;
   logic [CHSEL_W-1:0] channel_sel;
   logic [DATA_W-1:0] analog_pin_mode;
   logic conv_done_irq;
   logic [9:0] vin = 10'h000;
   logic [9:0] first_tap;
   logic [9:0] vals [4] = '{10'h3ff, 10'h000, 10'h2a5, 10'h15a};
   logic [7:0] d;
   int failures = 0;
   int tests_run = 0;
   int k;
   int k_samp;

   sadc_ctrl DUT (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_rdata(reg_rdata),
      .cmp_high(cmp_high),
      .tap_code(tap_code),
      .sample_en(sample_en),
      .channel_sel(channel_sel),
      .analog_pin_mode(analog_pin_mode),
      .conv_done_irq(conv_done_irq)
   );

   always #(CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;

   // ideal comparator; registered, so it settles inside each 2-cycle step
   always @(posedge sys_clk) begin
      cmp_high <= (vin >= tap_code);
   end

   //=============================================================
   // checks and bus tasks
   task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp,
                          input string msg);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("BAD t=%0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : chk_reg

   task automatic chk_pin(input logic [9:0] got, input logic [9:0] exp,
                          input string msg);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("BAD t=%0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : chk_pin

   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [2:0] a, output logic [7:0] v);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      v = reg_rdata;
   endtask : rd

   task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
      logic [7:0] v;
      rd(a, v);
      chk_reg(v, exp, $sformatf("reg %0d", a));
   endtask : rd_chk

   task automatic chk_irq(input logic exp);
      #1;
      chk_reg({7'h00, conv_done_irq}, {7'h00, exp}, "irq line");
   endtask : chk_irq

   // counts edges from the start write to the interrupt; notes first trial
   task automatic wait_done(output int n, output int s);
      n = 0;
      s = 0;
      first_tap = 10'h000;
      #1;
      while (conv_done_irq !== 1'b1 && n < 60) begin
         if (sample_en === 1'b1) s++;
         else if (s > 0 && first_tap == 10'h000) first_tap = tap_code;
         @(posedge sys_clk);
         #1;
         n++;
      end
   endtask : wait_done

   task automatic end_test(input string name);
      $display("test %s done", name);
   endtask : end_test

   task automatic summarize;
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : summarize

   //=============================================================
   // watchdog: whole run is well under a thousand cycles
   initial begin
      #100000;
      failures++;
      $display("BAD t=%0t watchdog expired", $time);
      summarize();
   end

   //=============================================================
   // tests
   initial begin
      repeat (5) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      for (int a = 0; a < 8; a++) rd_chk(3'(a), REG_RESET);
      chk_pin(tap_code, 10'h000, "tap after reset");
      end_test("reset");

      wr(ADDR_MODE, 8'h80);
      rd_chk(ADDR_MODE, 8'h00);
      rd_chk(ADDR_STATE, 8'h00);
      repeat (40) @(posedge sys_clk);
      rd_chk(ADDR_IRQ_STAT, 8'h00);
      end_test("start while stopped");

      wr(ADDR_IRQ_MASK, 8'h01);
      wr(ADDR_MODE, 8'h01);
      rd_chk(ADDR_STATE, 8'h02);
      repeat (STAB_CYCLES) @(posedge sys_clk);
      rd_chk(ADDR_STATE, 8'h03);
      end_test("enable");

      for (int i = 0; i < 4; i++) begin
         vin = vals[i];
         wr(ADDR_MODE, 8'h81);
         wait_done(k, k_samp);
         chk_irq(1'b1);
         chk_pin(first_tap, TRIAL_MSB, "first trial");
         // flag shows one cycle after the last decision
         chk_pin(10'(k), 10'(CONV_CYCLES + 1), "conversion");
         chk_pin(10'(k_samp), 10'(SAMPLE_CYCLES), "sampling");
         rd_chk(ADDR_RES_HI, vals[i][9:2]);
         rd_chk(ADDR_RES_LO, {vals[i][1:0], 6'h00});
         rd_chk(ADDR_MODE, 8'h01);
         wr(ADDR_IRQ_MASK, 8'h00);
         chk_irq(1'b0);
         wr(ADDR_IRQ_MASK, 8'h01);
         chk_irq(1'b1);
         wr(ADDR_CHSEL, 8'hff);
         rd_chk(ADDR_CHSEL, 8'h07);
         chk_pin({7'h00, channel_sel}, 10'h007, "channel pins");
         rd_chk(ADDR_IRQ_STAT, 8'h01);
         wr(ADDR_IRQ_STAT, 8'h01);
         chk_irq(1'b0);
         // a single start must not convert again
         repeat (40) @(posedge sys_clk);
         rd_chk(ADDR_IRQ_STAT, 8'h00);
         rd_chk(ADDR_STATE, 8'h03);
      end
      wr(ADDR_RES_HI, 8'h5a);
      rd_chk(ADDR_RES_HI, 8'h56);
      end_test("conversions");

      vin = 10'h0ff;
      wr(ADDR_MODE, 8'h81);
      repeat (8) @(posedge sys_clk);
      wr(ADDR_MODE, 8'h01);
      rd_chk(ADDR_STATE, 8'h03);
      repeat (40) @(posedge sys_clk);
      rd_chk(ADDR_IRQ_STAT, 8'h00);
      rd_chk(ADDR_RES_HI, 8'h56);
      end_test("abort");

      // read strobe taken on the very edge that stores the result
      wr(ADDR_MODE, 8'h81);
      repeat (CONV_CYCLES - 1) @(posedge sys_clk);
      rd(ADDR_RES_HI, d);
      chk_reg(d, 8'h56, "colliding read");
      rd_chk(ADDR_RES_HI, 8'h3f);
      rd_chk(ADDR_IRQ_STAT, 8'h01);
      wr(ADDR_IRQ_STAT, 8'h01);
      end_test("read collision");

      vin = 10'h3c3;
      wr(ADDR_MODE, 8'h81);
      repeat (CONV_CYCLES - 1) @(posedge sys_clk);
      wr(ADDR_MODE, 8'h01);
      repeat (5) @(posedge sys_clk);
      chk_irq(1'b0);
      rd_chk(ADDR_IRQ_STAT, 8'h00);
      rd_chk(ADDR_MODE, 8'h01);
      rd_chk(ADDR_RES_HI, 8'h3f);
      end_test("mode write collision");

      wr(ADDR_MODE, 8'h00);
      rd_chk(ADDR_STATE, 8'h00);
      // enable cleared in mid-conversion goes straight to stopped
      wr(ADDR_MODE, 8'h01);
      repeat (STAB_CYCLES) @(posedge sys_clk);
      wr(ADDR_MODE, 8'h81);
      repeat (8) @(posedge sys_clk);
      wr(ADDR_MODE, 8'h00);
      rd_chk(ADDR_STATE, 8'h00);
      repeat (40) @(posedge sys_clk);
      rd_chk(ADDR_IRQ_STAT, 8'h00);
      rd_chk(ADDR_RES_HI, 8'h3f);
      wr(ADDR_PIN_MODE, 8'ha5);
      rd_chk(ADDR_PIN_MODE, 8'ha5);
      chk_pin({2'b00, analog_pin_mode}, 10'h0a5, "pin mode lines");
      end_test("stop");
      summarize();
   end
endmodule : sadc_ctrl_tb
`default_nettype wire

// File: src/sadc_ctrl.sv
// module: converter control top with register port, state machine, interrupt
//
// Local design decisions: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module sadc_ctrl
   import sadc_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DATA_W-1:0] reg_rdata,
   input wire logic cmp_high,
   output logic [APPROX_BITS-1:0] tap_code,
   output logic sample_en,
   output logic [CHSEL_W-1:0] channel_sel,
   output logic [DATA_W-1:0] analog_pin_mode,
   output logic conv_done_irq
);
   //=============================================================
   // storage
   sadc_state_e state;
   sadc_state_e next_state;
   logic conv_enable;
   logic conv_start;
   logic next_enable;
   logic next_start;
   logic [CHSEL_W-1:0] channel_select_reg;
   logic [DATA_W-1:0] result_high_reg;
   logic [DATA_W-1:0] result_low_reg;
   logic [DATA_W-1:0] irq_stat;
   logic [DATA_W-1:0] irq_mask;
   logic [DATA_W-1:0] analog_pin_mode_reg;
   logic [4:0] stab_cnt;
   logic stab_ok;

   sadc_sar_if sar ();

   sadc_sar_core u_core (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .sar(sar.core)
   );

   //=============================================================
   // decode
   wire wr_mode = reg_wr && (reg_addr == ADDR_MODE);
   wire wr_chsel = reg_wr && (reg_addr == ADDR_CHSEL);
   wire wr_stat = reg_wr && (reg_addr == ADDR_IRQ_STAT);
   wire wr_mask = reg_wr && (reg_addr == ADDR_IRQ_MASK);
   wire wr_pin = reg_wr && (reg_addr == ADDR_PIN_MODE);
   wire wdata_enable = reg_wdata[MODE_ENABLE_BIT];
   wire wdata_start = reg_wdata[MODE_START_BIT];
   // a mode write in the completion cycle wins over the result store
   wire done_accept = sar.done && !wr_mode;
   wire [15:0] result_word =
      {sar.result, 6'h00};
   wire conv_done_flag = irq_stat[IRQ_DONE_BIT];

   //=============================================================
   // mode bits and state
   always_comb begin
      next_enable = conv_enable;
      next_start = conv_start;
      if (wr_mode) begin
         next_enable = wdata_enable;
         // start only counts once the converter already stands by
         next_start = wdata_start && wdata_enable
                      && (state != ST_STOP);
      end else if (sar.done) begin
         next_start = 1'b0;
      end
   end

   always_comb begin
      if (!next_enable) begin
         next_state = ST_STOP;
      end else if (next_start) begin
         next_state = ST_CONV;
      end else begin
         next_state = ST_STBY;
      end
   end

   assign sar.launch = (next_state == ST_CONV)
                       && ((state != ST_CONV) || sar.done);
   assign sar.abort = (state == ST_CONV) && (next_state != ST_CONV);
   assign sar.cmp_high = cmp_high;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         state <= ST_STOP;
         conv_enable <= 1'b0;
         conv_start <= 1'b0;
      end else begin
         state <= next_state;
         conv_enable <= next_enable;
         conv_start <= next_start;
      end
   end

   // stabilisation tracker; early starts still run, software judges them
   always_ff @(posedge sys_clk) begin
      if (!rst_n || !conv_enable) begin
         stab_cnt <= 5'h00;
         stab_ok <= 1'b0;
      end else if (stab_cnt == STAB_LAST) begin
         stab_ok <= 1'b1;
      end else begin
         stab_cnt <= stab_cnt + 5'h01;
      end
   end

   //=============================================================
   // registers written by software and by completion
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         channel_select_reg <= 3'h0;
         irq_mask <= REG_RESET;
         analog_pin_mode_reg <= REG_RESET;
         result_high_reg <= REG_RESET;
         result_low_reg <= REG_RESET;
      end else begin
         if (wr_chsel) begin
            channel_select_reg <= reg_wdata[CHSEL_W-1:0];
         end
         if (wr_mask) begin
            irq_mask <= reg_wdata;
         end
         if (wr_pin) begin
            analog_pin_mode_reg <= reg_wdata;
         end
         // a read in this cycle already sampled the old value
         if (done_accept) begin
            result_high_reg <= result_word[15:8];
            result_low_reg <= result_word[7:0];
         end
      end
   end

   // write one to clear; a new event in the same cycle still sets
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         irq_stat <= REG_RESET;
      end else begin
         irq_stat[IRQ_DONE_BIT] <= done_accept
            || (conv_done_flag
                && !(wr_stat && reg_wdata[IRQ_DONE_BIT]));
      end
   end

   //=============================================================
   // read port
   wire [DATA_W-1:0] mode_view =
      {conv_start, 6'h00, conv_enable};
   wire [DATA_W-1:0] state_view =
      {5'h00, state, stab_ok};
   wire [DATA_W-1:0] rd_mux =
      (reg_addr == ADDR_MODE) ? mode_view :
      (reg_addr == ADDR_CHSEL) ? {5'h00, channel_select_reg} :
      (reg_addr == ADDR_RES_HI) ? result_high_reg :
      (reg_addr == ADDR_RES_LO) ? result_low_reg :
      (reg_addr == ADDR_IRQ_STAT) ? irq_stat :
      (reg_addr == ADDR_IRQ_MASK) ? irq_mask :
      (reg_addr == ADDR_PIN_MODE) ? analog_pin_mode_reg :
      state_view;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         reg_rdata <= REG_RESET;
      end else if (reg_rd) begin
         reg_rdata <= rd_mux;
      end else begin
         reg_rdata <= REG_RESET;
      end
   end

   //=============================================================
   // outputs
   assign conv_done_irq = |(irq_stat & irq_mask);
   assign tap_code = sar.tap_code;
   assign sample_en = sar.sampling;
   assign channel_sel = channel_select_reg;
   assign analog_pin_mode = analog_pin_mode_reg;

   //=============================================================
   // checks
   localparam int CONV_LAT = CONV_CYCLES;
   logic [7:0] conv_age;

   always_ff @(posedge sys_clk) begin
      if (!rst_n || sar.launch) begin
         conv_age <= 8'h00;
      end else if (conv_age != 8'hff) begin
         conv_age <= conv_age + 8'h01;
      end
   end

   sequence s_mode_write(logic en, logic st);
      wr_mode && (wdata_enable == en) && (wdata_start == st);
   endsequence

   sequence s_launch;
      sar.launch && !sar.abort;
   endsequence

   property p_result_scale;
      @(posedge sys_clk) disable iff (!rst_n)
      done_accept |=> {result_high_reg, result_low_reg}
         == {$past(sar.result), 6'h00};
   endproperty
   a_result_scale: assert property (p_result_scale)
      else $error("result word is not the left aligned value");

   property p_enable_to_standby;
      @(posedge sys_clk) disable iff (!rst_n)
      (state == ST_STOP) ##0 s_mode_write(1'b1, 1'b0)
         |=> (state == ST_STBY) && conv_enable;
   endproperty
   a_enable_to_standby: assert property (p_enable_to_standby)
      else $error("enable from stopped did not reach standby");

   property p_done_sets_flag;
      @(posedge sys_clk) disable iff (!rst_n)
      done_accept |=> conv_done_flag
         && (irq_mask[IRQ_DONE_BIT] == conv_done_irq);
   endproperty
   a_done_sets_flag: assert property (p_done_sets_flag)
      else $error("completion did not raise the done request");

   property p_one_shot;
      @(posedge sys_clk) disable iff (!rst_n)
      (sar.done && !wr_mode) |=> !conv_start && (state == ST_STBY);
   endproperty
   a_one_shot: assert property (p_one_shot)
      else $error("start bit not cleared after completion");

   property p_abort;
      @(posedge sys_clk) disable iff (!rst_n)
      (state == ST_CONV) ##0 s_mode_write(1'b1, 1'b0)
         |=> (state == ST_STBY) ##1 !sar.done [*3];
   endproperty
   a_abort: assert property (p_abort)
      else $error("cleared start did not abandon the conversion");

   property p_disable_to_stop;
      @(posedge sys_clk) disable iff (!rst_n)
      (state == ST_STBY) ##0 s_mode_write(1'b0, 1'b0)
         |=> (state == ST_STOP);
   endproperty
   a_disable_to_stop: assert property (p_disable_to_stop)
      else $error("cleared enable in standby did not stop");

   property p_start_ignored;
      @(posedge sys_clk) disable iff (!rst_n)
      (state == ST_STOP) && wr_mode && wdata_start
         |=> !conv_start ##1 !sar.sampling;
   endproperty
   a_start_ignored: assert property (p_start_ignored)
      else $error("start accepted while stopped");

   property p_read_first;
      @(posedge sys_clk) disable iff (!rst_n)
      reg_rd && (reg_addr == ADDR_RES_HI) && done_accept
         |=> reg_rdata == $past(result_high_reg);
   endproperty
   a_read_first: assert property (p_read_first)
      else $error("collided read did not return the old result");

   property p_mode_wins;
      @(posedge sys_clk) disable iff (!rst_n)
      sar.done && wr_mode && !conv_done_flag
         |=> $stable(result_high_reg) && $stable(result_low_reg)
             && !conv_done_flag;
   endproperty
   a_mode_wins: assert property (p_mode_wins)
      else $error("result stored despite colliding mode write");

   property p_flag_kept;
      @(posedge sys_clk) disable iff (!rst_n)
      wr_chsel && conv_done_flag |=> conv_done_flag;
   endproperty
   a_flag_kept: assert property (p_flag_kept)
      else $error("channel select write cleared the done flag");

   property p_msb_first;
      @(posedge sys_clk) disable iff (!rst_n)
      s_launch ##1 !sar.abort [*4] |=> (sar.tap_code == TRIAL_MSB);
   endproperty
   a_msb_first: assert property (p_msb_first)
      else $error("approximation did not start at the top bit");

   property p_conv_length;
      @(posedge sys_clk) disable iff (!rst_n)
      sar.done |-> (conv_age == 8'(CONV_LAT));
   endproperty
   a_conv_length: assert property (p_conv_length)
      else $error("conversion length differs from the fixed count");

   property p_result_held;
      @(posedge sys_clk) disable iff (!rst_n)
      !done_accept |=> $stable(result_high_reg) && $stable(result_low_reg);
   endproperty
   a_result_held: assert property (p_result_held)
      else $error("result registers changed outside a completion");

   property p_start_needs_enable;
      @(posedge sys_clk) disable iff (!rst_n)
      wr_mode && wdata_start && !wdata_enable
         |=> !conv_start && (state == ST_STOP);
   endproperty
   a_start_needs_enable: assert property (p_start_needs_enable)
      else $error("start taken without the enable bit");

   property p_done_in_conv;
      @(posedge sys_clk) disable iff (!rst_n)
      (state != ST_CONV) |-> !sar.done;
   endproperty
   a_done_in_conv: assert property (p_done_in_conv)
      else $error("completion outside a running conversion");

   property p_sample_first;
      @(posedge sys_clk) disable iff (!rst_n)
      s_launch |=> sar.sampling;
   endproperty
   a_sample_first: assert property (p_sample_first)
      else $error("conversion did not open with sampling");

   property p_disable_mid_conv;
      @(posedge sys_clk) disable iff (!rst_n)
      (state == ST_CONV) ##0 s_mode_write(1'b0, 1'b0)
         |=> (state == ST_STOP);
   endproperty
   a_disable_mid_conv: assert property (p_disable_mid_conv)
      else $error("cleared enable while converting did not stop");

endmodule : sadc_ctrl
`default_nettype wire

// File: src/sadc_pkg.sv
// package: constants, register map and state types of the converter control
//=============================================================
// Contract
// - result word is approximation times 64
// - enable set while stopped enters standby
// - completion stores result, raises done request
// - completion clears start, returns to standby
// - clearing start mid-conversion aborts to standby
// - clearing enable in standby enters stopped
// - start written while stopped is ignored
// - result read beats end-of-conversion write
// - mode write at completion drops result, interrupt
// - channel select write keeps done flag
// - high byte upper eight, low top two
// - approximation runs from bit 9 down
package sadc_pkg;

   //=============================================================
   // timing
   localparam int CLK_PERIOD_NS = 8;
   localparam int STAB_TIME_NS = 100;
   localparam int STAB_CYCLES =
      (STAB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SAMPLE_CYCLES = 4;
   localparam int BIT_CYCLES = 2;
   localparam int APPROX_BITS = 10;
   localparam int CONV_CYCLES = SAMPLE_CYCLES + APPROX_BITS * BIT_CYCLES;
   localparam logic [4:0] STAB_LAST = 5'(STAB_CYCLES - 1);
   localparam logic [3:0] SAMPLE_LAST = 4'(SAMPLE_CYCLES - 1);
   localparam logic [3:0] BIT_LAST = 4'(BIT_CYCLES - 1);
   localparam logic [3:0] TOP_BIT = 4'(APPROX_BITS - 1);
   localparam logic [9:0] TRIAL_MSB = 10'h200;
   localparam logic [9:0] ONE_LSB = 10'h001;

   //=============================================================
   // register map
   localparam int ADDR_W = 3;
   localparam int DATA_W = 8;
   localparam logic [2:0] ADDR_MODE = 3'h0;
   localparam logic [2:0] ADDR_CHSEL = 3'h1;
   localparam logic [2:0] ADDR_RES_HI = 3'h2;
   localparam logic [2:0] ADDR_RES_LO = 3'h3;
   localparam logic [2:0] ADDR_IRQ_STAT = 3'h4;
   localparam logic [2:0] ADDR_IRQ_MASK = 3'h5;
   localparam logic [2:0] ADDR_PIN_MODE = 3'h6;
   localparam logic [2:0] ADDR_STATE = 3'h7;
   localparam int MODE_START_BIT = 7;
   localparam int MODE_ENABLE_BIT = 0;
   localparam int CHSEL_W = 3;
   localparam int IRQ_DONE_BIT = 0;
   localparam int RESULT_SHIFT = 6;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [9:0] RESULT_RESET = 10'h000;

   //=============================================================
   // states
   typedef enum logic [1:0] {
      ST_STOP = 2'b00,
      ST_STBY = 2'b01,
      ST_CONV = 2'b10
   } sadc_state_e;

   typedef enum logic [1:0] {
      SAR_IDLE = 2'b00,
      SAR_SAMPLE = 2'b01,
      SAR_COMPARE = 2'b10
   } sadc_sar_e;

endpackage : sadc_pkg

// File: src/sadc_sar_core.sv
// module: successive approximation sequencer, one bit per compare step
`timescale 1ns/10ps
`default_nettype none
module sadc_sar_core
   import sadc_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   sadc_sar_if.core sar
);
   sadc_sar_e state;
   logic [3:0] cnt;
   logic [3:0] bit_idx;
   logic [APPROX_BITS-1:0] approx_reg;
   logic [APPROX_BITS-1:0] decided;
   logic [APPROX_BITS-1:0] next_trial;

   // keep trial bit when sample is at or above the tap
   assign decided = sar.cmp_high ? approx_reg
                  : approx_reg & ~(ONE_LSB << bit_idx);
   assign next_trial = decided | (ONE_LSB << (bit_idx - 4'h1));
   assign sar.tap_code = approx_reg;
   assign sar.sampling = (state == SAR_SAMPLE);

   //=============================================================
   // sequencer
   always_ff @(posedge sys_clk) begin
      sar.done <= 1'b0;
      if (!rst_n) begin
         state <= SAR_IDLE;
         cnt <= 4'h0;
         bit_idx <= 4'h0;
         approx_reg <= RESULT_RESET;
         sar.result <= RESULT_RESET;
      end else if (sar.abort) begin
         state <= SAR_IDLE;
         cnt <= 4'h0;
      end else begin
         case (state)
            SAR_IDLE: begin
               if (sar.launch) begin
                  state <= SAR_SAMPLE;
                  cnt <= 4'h0;
                  approx_reg <= RESULT_RESET;
               end
            end
            SAR_SAMPLE: begin
               cnt <= cnt + 4'h1;
               if (cnt == SAMPLE_LAST) begin
                  state <= SAR_COMPARE;
                  cnt <= 4'h0;
                  bit_idx <= TOP_BIT;
                  approx_reg <= TRIAL_MSB;
               end
            end
            SAR_COMPARE: begin
               cnt <= cnt + 4'h1;
               if (cnt == BIT_LAST) begin
                  cnt <= 4'h0;
                  if (bit_idx == 4'h0) begin
                     approx_reg <= decided;
                     sar.result <= decided;
                     sar.done <= 1'b1;
                     state <= SAR_IDLE;
                  end else begin
                     approx_reg <= next_trial;
                     bit_idx <= bit_idx - 4'h1;
                  end
               end
            end
            default: begin
               state <= SAR_IDLE;
            end
         endcase
      end
   end
endmodule : sadc_sar_core
`default_nettype wire

// File: src/sadc_sar_if.sv
// interface: control and result lines between controller and approximation core
`timescale 1ns/10ps
`default_nettype none
interface sadc_sar_if
   import sadc_pkg::*;
();
   logic launch;
   logic abort;
   logic done;
   logic cmp_high;
   logic sampling;
   logic [APPROX_BITS-1:0] result;
   logic [APPROX_BITS-1:0] tap_code;

   modport ctrl (
      output launch,
      output abort,
      output cmp_high,
      input done,
      input sampling,
      input result,
      input tap_code
   );

   modport core (
      input launch,
      input abort,
      input cmp_high,
      output done,
      output sampling,
      output result,
      output tap_code
   );
endinterface : sadc_sar_if
`default_nettype wire
